// ===== ccn_pkg.sv
package ccn_pkg;

    // ------------------------------------------------------------
    // I/O ports of the index/data pair
    // ------------------------------------------------------------
    localparam logic [15:0] CCN_PORT_INDEX = 16'h0022;
    localparam logic [15:0] CCN_PORT_DATA = 16'h0023;

    // ------------------------------------------------------------
    // Register indices
    // ------------------------------------------------------------
    localparam logic [7:0] CCN_IDX_LO = 8'hc0;
    localparam logic [7:0] CCN_IDX_HI = 8'hcf;
    localparam logic [7:0] CCN_IDX_CTRL_A = 8'hc0;
    localparam logic [7:0] CCN_IDX_CTRL_B = 8'hc1;
    localparam logic [7:0] CCN_IDX_R1_HIGH = 8'hc5;
    localparam logic [7:0] CCN_IDX_R1_LOW = 8'hc6;
    localparam logic [7:0] CCN_IDX_R2_HIGH = 8'hc8;
    localparam logic [7:0] CCN_IDX_R2_LOW = 8'hc9;
    localparam logic [7:0] CCN_IDX_R3_HIGH = 8'hcb;
    localparam logic [7:0] CCN_IDX_R3_LOW = 8'hcc;
    localparam logic [7:0] CCN_IDX_R4_HIGH = 8'hce;
    localparam logic [7:0] CCN_IDX_R4_LOW = 8'hcf;

    // ------------------------------------------------------------
    // Field positions of cache_config_ctrl_a / _b
    // ------------------------------------------------------------
    localparam int CCN_A_LOW64K = 0;
    localparam int CCN_A_VIDEO = 1;
    localparam int CCN_A_A20EN = 2;
    localparam int CCN_A_KENEN = 3;
    localparam int CCN_A_FLUSHEN = 4;
    localparam int CCN_A_HOLDINV = 5;
    localparam int CCN_A_WAYMODE = 6;
    localparam int CCN_A_SUSPEN = 7;
    localparam int CCN_B_RPLEN = 0;
    localparam logic [7:0] CCN_B_WMASK = 8'h01;

    // ------------------------------------------------------------
    // Reset values and size codes
    // ------------------------------------------------------------
    localparam logic [7:0] CCN_RST_ZERO = 8'h00;
    localparam logic [7:0] CCN_RST_R1_LOW = 8'h0f;
    localparam logic [3:0] CCN_SIZE_OFF = 4'h0;
    localparam logic [3:0] CCN_SIZE_ALL = 4'hf;
    localparam int CCN_PAGE_BIT = 12;

    // ------------------------------------------------------------
    // Fixed region bounds
    // ------------------------------------------------------------
    localparam logic [19:0] CCN_VIDEO_BASE = 20'ha_0000;
    localparam int CCN_MEG_BIT = 20;
    localparam int CCN_64K_BIT = 16;
    localparam int CCN_ADDR20 = 20;

    // Index port sequencing
    typedef enum logic [0:0] {
        CCN_IDLE = 1'b0,
        CCN_ARMED = 1'b1
    } ccn_state_t;

endpackage

// ===== ccn_region_match.sv
`timescale 1ns/100ps

// Compares one address against one programmable uncached region
module ccn_region_match
    import ccn_pkg::*;
(
    // Region setting
    input wire logic [7:0] base_high,
    input wire logic [7:0] base_low_size,
    // Address under test
    input wire logic [31:0] addr,
    // Result
    output logic hit
);

    logic [3:0] size_code;
    logic [31:0] base;
    logic [31:0] diff;

    // Start address is 24 bits; everything above bit 23 is zero
    assign size_code = base_low_size[3:0];
    assign base = {8'h00, base_high, base_low_size[7:4], 12'h000};

    // ------------------------------------------------------------
    // Per-bit compare above the block size
    // ------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < 32; gi++)
        begin : g_bit
            if (gi < CCN_PAGE_BIT)
            begin : g_low
                assign diff[gi] = 1'b0;
            end
            else
            begin : g_cmp
                // Bit is examined only when it lies above the block
                localparam logic [4:0] LEVEL = 5'(gi - CCN_PAGE_BIT + 1);
                assign diff[gi] = ({1'b0, size_code} <= LEVEL)
                    && (addr[gi] != base[gi]);
            end
        end
    endgenerate

    // Disabled, whole space, or block match
    always_comb
    begin
        if (size_code == CCN_SIZE_OFF)
            hit = 1'b0;
        else if (size_code == CCN_SIZE_ALL)
            hit = 1'b1;
        else
            hit = (diff == 32'h0000_0000);
    end

endmodule // ccn_region_match

// ===== ccn_config_bank.sv
`timescale 1ns/100ps

// Overview of operation
// - With ctrl_a bit 0 set in real or v86 mode, the first 64 KB of every megabyte is uncached.
// - With ctrl_a bit 1 set, the range 640 KB up to 1 MB is uncached.
// - The address-bit-20 mask input acts only while ctrl_a bit 2 is set.
// - The external cacheable input acts only while ctrl_a bit 3 is set.
// - The external invalidate input acts only while ctrl_a bit 4 is set.
// - With ctrl_a bit 5 set, entering bus hold invalidates the whole cache.
// - Ctrl_a bit 6 picks two-way (0) or direct-mapped (1) organisation.
// - Ctrl_a bit 7 enables suspend request and acknowledge; when clear the acknowledge floats.
// - Ctrl_b bit 0 enables both replacement pins, which float when clear; bits 7 to 1 are reserved.
// - The first byte of each region holds start address bits 23 to 16.
// - The second byte holds start address bits 15 to 12 above a 4-bit size code.
// - Size code 0 disables, 1 is 4 KB doubling up to 32 MB at E, and F is 4 GB.
// - Reset clears every bit except region one's second byte, which becomes 0Fh.
// - Out-of-range index writes go to the external bus; in-range accesses stay inside.
// - Region starts align to block size, and the 4 GB size uncaches everything.
module ccn_config_bank
    import ccn_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic arst_n,
    // Processor I/O cycle request
    input wire logic io_req,
    input wire logic io_write,
    input wire logic [15:0] io_port,
    input wire logic [7:0] io_wdata,
    // I/O cycle answer
    output logic io_claim,
    output logic io_ext,
    output logic [7:0] io_rdata,
    // Memory access under test
    input wire logic [31:0] mem_addr,
    input wire logic real_v86_mode,
    output logic [31:0] mem_addr_eff,
    output logic mem_noncacheable,
    // External pins and core status
    input wire logic addr20_mask_input_n,
    input wire logic cacheable_input_n,
    input wire logic cache_flush_input_n,
    input wire logic hold_ack,
    input wire logic suspend_request_input_n,
    input wire logic core_suspended,
    input wire logic core_rpl_set,
    input wire logic core_rpl_valid,
    // Cache control to the core
    output logic way_mode_select,
    output logic cache_invalidate,
    output logic suspend_req,
    // Two-way pin drivers
    output logic suspend_ack_output_n,
    output logic suspend_ack_oe,
    output logic replacement_set_output,
    output logic replacement_set_oe,
    output logic replacement_valid_output_n,
    output logic replacement_valid_oe
);

    // ------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------

    // True for an index that holds a real register
    function automatic logic idx_impl(input logic [7:0] idx);
        unique case (idx)
            CCN_IDX_CTRL_A, CCN_IDX_CTRL_B,
            CCN_IDX_R1_HIGH, CCN_IDX_R1_LOW,
            CCN_IDX_R2_HIGH, CCN_IDX_R2_LOW,
            CCN_IDX_R3_HIGH, CCN_IDX_R3_LOW,
            CCN_IDX_R4_HIGH, CCN_IDX_R4_LOW: idx_impl = 1'b1;
            default: idx_impl = 1'b0;
        endcase
    endfunction

    // Writable bits of each index; reserved bits stay zero
    function automatic logic [7:0] idx_wmask(input logic [7:0] idx);
        if (idx == CCN_IDX_CTRL_B)
            idx_wmask = CCN_B_WMASK;
        else if (idx_impl(idx))
            idx_wmask = 8'hff;
        else
            idx_wmask = 8'h00;
    endfunction

    // Value taken at reset by each index
    function automatic logic [7:0] idx_reset(input logic [7:0] idx);
        if (idx == CCN_IDX_R1_LOW)
            idx_reset = CCN_RST_R1_LOW;
        else
            idx_reset = CCN_RST_ZERO;
    endfunction

    // True for an index inside the configuration window
    function automatic logic idx_in_range(input logic [7:0] idx);
        idx_in_range = (idx >= CCN_IDX_LO) && (idx <= CCN_IDX_HI);
    endfunction

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    ccn_state_t state;
    ccn_state_t next_state;
    logic [7:0] index;
    logic [7:0] next_index;
    logic [7:0] cfg [0:15];
    logic [7:0] next_cfg [0:15];
    logic [7:0] rdata;
    logic [7:0] next_rdata;
    logic claim;
    logic next_claim;
    logic ext;
    logic next_ext;

    logic idx_wr;
    logic data_acc;
    logic [3:0] slot;
    logic [7:0] ctrl_a;
    logic [7:0] ctrl_b;

    // Array slot is the low nibble of a C0h..CFh index
    assign slot = index[3:0];
    assign ctrl_a = cfg[CCN_IDX_CTRL_A[3:0]];
    assign ctrl_b = cfg[CCN_IDX_CTRL_B[3:0]];
    assign idx_wr = io_req && io_write && (io_port == CCN_PORT_INDEX);
    assign data_acc = io_req && (io_port == CCN_PORT_DATA);

    // ------------------------------------------------------------
    // Index/data port sequencing and register writes
    // ------------------------------------------------------------
    // One index write arms exactly one data access; a second data
    // access without a fresh index falls through to the bus.
    always_comb
    begin
        next_state = state;
        next_index = index;
        next_rdata = rdata;
        next_claim = 1'b0;
        next_ext = 1'b0;
        for (int i = 0; i < 16; i++)
        begin
            next_cfg[i] = cfg[i];
        end
        if (idx_wr)
        begin
            if (idx_in_range(io_wdata))
            begin
                next_state = CCN_ARMED;
                next_index = io_wdata;
                next_claim = 1'b1;
            end
            else
            begin
                next_state = CCN_IDLE;
                next_ext = 1'b1;
            end
        end
        else if (data_acc)
        begin
            unique case (state)
                CCN_ARMED:
                begin
                    next_state = CCN_IDLE;
                    next_claim = 1'b1;
                    if (io_write)
                    begin
                        next_cfg[slot] = (io_wdata & idx_wmask(index))
                            | (cfg[slot] & ~idx_wmask(index));
                    end
                    else
                    begin
                        // Unimplemented indices in the window read zero
                        next_rdata = cfg[slot] & idx_wmask(index);
                    end
                end
                CCN_IDLE:
                begin
                    next_ext = 1'b1;
                end
            endcase
        end
        else if (io_req)
        begin
            // Any other port, or an index read, is not ours
            next_ext = 1'b1;
        end
    end

    // Registers; reset values come from idx_reset
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state <= CCN_IDLE;
            index <= CCN_RST_ZERO;
            rdata <= CCN_RST_ZERO;
            claim <= 1'b0;
            ext <= 1'b0;
            for (int i = 0; i < 16; i++)
            begin
                cfg[i] <= idx_reset({4'hc, 4'(i)});
            end
        end
        else
        begin
            state <= next_state;
            index <= next_index;
            rdata <= next_rdata;
            claim <= next_claim;
            ext <= next_ext;
            for (int i = 0; i < 16; i++)
            begin
                cfg[i] <= next_cfg[i];
            end
        end
    end

    assign io_claim = claim;
    assign io_ext = ext;
    assign io_rdata = rdata;

    // ------------------------------------------------------------
    // Programmable regions
    // ------------------------------------------------------------
    logic [3:0] region_hit;
    logic [31:0] addr_masked;

    genvar gr;
    generate
        for (gr = 0; gr < 4; gr++)
        begin : g_region
            // Regions sit at C5h, C8h, CBh, CEh: three indices apart
            localparam logic [3:0] HI_SLOT =
                4'(CCN_IDX_R1_HIGH[3:0] + 3 * gr);
            localparam logic [3:0] LO_SLOT = 4'(HI_SLOT + 1);
            ccn_region_match u_match (
                .base_high(cfg[HI_SLOT]),
                .base_low_size(cfg[LO_SLOT]),
                .addr(addr_masked),
                .hit(region_hit[gr])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // Address masking and cacheability
    // ------------------------------------------------------------
    logic fixed_low64k;
    logic fixed_video;
    logic ext_uncached;
    logic [31:0] next_addr_eff;
    logic next_nc;
    logic [31:0] addr_eff;
    logic nc;

    // Pin is ignored unless enabled, so a stray low cannot alias
    always_comb
    begin
        addr_masked = mem_addr;
        if (ctrl_a[CCN_A_A20EN] && !addr20_mask_input_n)
            addr_masked[CCN_ADDR20] = 1'b0;
    end

    // Fixed holes: 64 KB at each meg, and 640 KB..1 MB
    assign fixed_low64k = ctrl_a[CCN_A_LOW64K] && real_v86_mode
        && (addr_masked[CCN_MEG_BIT-1:CCN_64K_BIT] == 4'h0);
    assign fixed_video = ctrl_a[CCN_A_VIDEO]
        && (addr_masked[31:CCN_MEG_BIT] == 12'h000)
        && (addr_masked[CCN_MEG_BIT-1:0] >= CCN_VIDEO_BASE);
    // High on the cacheable pin means the line may not be cached
    assign ext_uncached = ctrl_a[CCN_A_KENEN] && cacheable_input_n;

    // Combine every source of uncached status
    always_comb
    begin
        next_addr_eff = addr_masked;
        next_nc = fixed_low64k || fixed_video || ext_uncached
            || (region_hit != 4'h0);
    end

    // Registered so the core sees a glitch-free decision
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            addr_eff <= 32'h0000_0000;
            nc <= 1'b0;
        end
        else
        begin
            addr_eff <= next_addr_eff;
            nc <= next_nc;
        end
    end

    assign mem_addr_eff = addr_eff;
    assign mem_noncacheable = nc;

    // ------------------------------------------------------------
    // Invalidate and hold tracking
    // ------------------------------------------------------------
    logic hold_seen;
    logic next_hold_seen;
    logic inval;
    logic next_inval;

    // Pin invalidate and hold entry share one pulse to the core
    always_comb
    begin
        next_hold_seen = hold_ack;
        next_inval = 1'b0;
        if (ctrl_a[CCN_A_FLUSHEN] && !cache_flush_input_n)
            next_inval = 1'b1;
        if (ctrl_a[CCN_A_HOLDINV] && hold_ack && !hold_seen)
            next_inval = 1'b1;
    end

    // Edge memory for hold entry
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            hold_seen <= 1'b0;
            inval <= 1'b0;
        end
        else
        begin
            hold_seen <= next_hold_seen;
            inval <= next_inval;
        end
    end

    assign cache_invalidate = inval;

    // ------------------------------------------------------------
    // Organisation, suspend and replacement pins
    // ------------------------------------------------------------
    assign way_mode_select = ctrl_a[CCN_A_WAYMODE];
    assign suspend_req = ctrl_a[CCN_A_SUSPEN]
        && !suspend_request_input_n;
    assign suspend_ack_output_n = !core_suspended;
    assign suspend_ack_oe = ctrl_a[CCN_A_SUSPEN];
    assign replacement_set_output = core_rpl_set;
    assign replacement_set_oe = ctrl_b[CCN_B_RPLEN];
    assign replacement_valid_output_n = !core_rpl_valid;
    assign replacement_valid_oe = ctrl_b[CCN_B_RPLEN];

endmodule // ccn_config_bank

// ===== ccn_config_bank_sva.sv
`timescale 1ns/100ps

// ------------------------------------------------------------
// Port checks of the config bank
// ------------------------------------------------------------
module ccn_config_bank_sva
    import ccn_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic arst_n,
    // I/O cycle
    input wire logic io_req,
    input wire logic io_write,
    input wire logic [15:0] io_port,
    input wire logic [7:0] io_wdata,
    input wire logic io_claim,
    input wire logic io_ext,
    input wire logic [7:0] io_rdata,
    // Memory side
    input wire logic [31:0] mem_addr,
    input wire logic [31:0] mem_addr_eff,
    input wire logic addr20_mask_input_n,
    // Pins and core status
    input wire logic cache_flush_input_n,
    input wire logic hold_ack,
    input wire logic cache_invalidate,
    input wire logic suspend_request_input_n,
    input wire logic core_suspended,
    input wire logic core_rpl_set,
    input wire logic core_rpl_valid,
    input wire logic way_mode_select,
    input wire logic suspend_req,
    input wire logic suspend_ack_output_n,
    input wire logic suspend_ack_oe,
    input wire logic replacement_set_output,
    input wire logic replacement_set_oe,
    input wire logic replacement_valid_output_n,
    input wire logic replacement_valid_oe
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!arst_n);

    // Index port writes, split by range
    wire logic idx_wr = io_req && io_write && io_port == CCN_PORT_INDEX;
    wire logic in_rng = io_wdata inside {[CCN_IDX_LO:CCN_IDX_HI]};

    answer_once_a: assert property (io_req |=> io_claim != io_ext)
        else $error("io request not answered exactly once");
    no_answer_a: assert property (!io_req |=> !io_claim && !io_ext)
        else $error("io answer without request");
    idx_claim_a: assert property (idx_wr && in_rng |=> io_claim)
        else $error("in range index not claimed");
    idx_ext_a: assert property (idx_wr && !in_rng |=> io_ext)
        else $error("out of range index not external");
    other_port_a: assert property (
        io_req && io_port != CCN_PORT_INDEX && io_port != CCN_PORT_DATA
        |=> io_ext) else $error("foreign port not external");
    rdata_hold_a: assert property (!io_claim |-> $stable(io_rdata))
        else $error("read data moved without claim");
    way_hold_a: assert property (!io_claim |-> $stable(way_mode_select))
        else $error("way mode moved without claim");
    addr_pass_a: assert property (
        arst_n |=> mem_addr_eff[31:21] == $past(mem_addr[31:21])
        && mem_addr_eff[19:0] == $past(mem_addr[19:0])
        && (!$past(addr20_mask_input_n)
        || mem_addr_eff[20] == $past(mem_addr[20])))
        else $error("effective address corrupted");
    inval_cause_a: assert property (
        cache_invalidate |-> !$past(cache_flush_input_n)
        || ($past(hold_ack) && !$past(hold_ack, 2)))
        else $error("invalidate without cause");
    suspend_request_input_pins_a: assert property (
        suspend_req == (suspend_ack_oe && !suspend_request_input_n)
        && (!suspend_ack_oe || suspend_ack_output_n == !core_suspended))
        else $error("suspend pins wrong");
    rpl_pins_a: assert property (
        replacement_set_oe == replacement_valid_oe && (!replacement_set_oe
        || (replacement_set_output == core_rpl_set
        && replacement_valid_output_n == !core_rpl_valid)))
        else $error("replacement pins wrong");
endmodule // ccn_config_bank_sva

bind ccn_config_bank ccn_config_bank_sva u_ccn_config_bank_sva (
    .mclk, .arst_n, .io_req, .io_write, .io_port, .io_wdata, .io_claim,
    .io_ext, .io_rdata, .mem_addr, .mem_addr_eff, .addr20_mask_input_n,
    .cache_flush_input_n, .hold_ack, .cache_invalidate,
    .suspend_request_input_n, .core_suspended, .core_rpl_set,
    .core_rpl_valid, .way_mode_select, .suspend_req, .suspend_ack_output_n,
    .suspend_ack_oe, .replacement_set_output, .replacement_set_oe,
    .replacement_valid_output_n, .replacement_valid_oe);

// ===== tb_top.sv
`timescale 1ns/100ps

// ------------------------------------------------------------
// Random and corner tests of the config bank
// ------------------------------------------------------------
module tb_top
    import ccn_pkg::*;
;
    logic mclk = 0, arst_n = 0, io_req = 0, io_write = 0;
    logic [15:0] io_port = 0;
    logic [7:0] io_wdata = 0;
    logic [31:0] mem_addr = 0;
    logic real_v86_mode = 0, addr20_mask_input_n = 1, cacheable_input_n = 1;
    logic cache_flush_input_n = 1, hold_ack = 0, suspend_request_input_n = 1;
    logic core_suspended = 0, core_rpl_set = 0, core_rpl_valid = 0;
    logic io_claim, io_ext, mem_noncacheable, way_mode_select;
    logic cache_invalidate, suspend_req, suspend_ack_output_n;
    logic suspend_ack_oe, replacement_set_output, replacement_set_oe;
    logic replacement_valid_output_n, replacement_valid_oe;
    logic [7:0] io_rdata;
    logic [31:0] mem_addr_eff;
    logic [7:0] rg [16];
    integer seed = 70377, error_cnt = 0, tests_run = 0, cyc = 0;

    ccn_config_bank u_ccn_config_bank (
        .mclk, .arst_n, .io_req, .io_write, .io_port, .io_wdata, .io_claim,
        .io_ext, .io_rdata, .mem_addr, .real_v86_mode, .mem_addr_eff,
        .mem_noncacheable, .addr20_mask_input_n, .cacheable_input_n,
        .cache_flush_input_n, .hold_ack, .suspend_request_input_n,
        .core_suspended, .core_rpl_set, .core_rpl_valid, .way_mode_select,
        .cache_invalidate, .suspend_req, .suspend_ack_output_n,
        .suspend_ack_oe, .replacement_set_output, .replacement_set_oe,
        .replacement_valid_output_n, .replacement_valid_oe);

    // Free running clock
    initial forever #20 mclk = ~mclk;

    task automatic finish_test();
        if (error_cnt == 0 && tests_run > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // Hang guard, far above the expected run length
    always @(posedge mclk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            error_cnt++;
            finish_test();
        end
    end

    task automatic chk(input string nm, input logic [31:0] got, exp);
        tests_run++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("ERROR %s exp %h got %h", nm, exp, got);
        end
    endtask

    // One I/O cycle; the answer stands in the cycle after the request edge
    task automatic io(input logic w, input logic [15:0] p,
        input logic [7:0] d, input logic ext);
        @(posedge mclk);
        io_req <= 1;
        io_write <= w;
        io_port <= p;
        io_wdata <= d;
        @(posedge mclk);
        io_req <= 0;
        #1;
        chk("claim", io_claim, !ext);
        chk("ext", io_ext, ext);
    endtask

    // Indexed write; the model keeps only implemented bits
    task automatic wr(input logic [7:0] i, d);
        io(1, CCN_PORT_INDEX, i, 0);
        io(1, CCN_PORT_DATA, d, 0);
        if (i[3:0] == 1) rg[1] = d & CCN_B_WMASK;
        else if (!(i[3:0] inside {2, 3, 4, 7, 10, 13})) rg[i[3:0]] = d;
    endtask

    task automatic rd(input logic [7:0] i);
        io(1, CCN_PORT_INDEX, i, 0);
        io(0, CCN_PORT_DATA, 8'h00, 0);
        chk("rdata", io_rdata, rg[i[3:0]]);
    endtask

    // Reset, then every index must read its default
    task automatic do_reset();
        arst_n <= 0;
        hold_ack <= 0;
        repeat (16) @(posedge mclk);
        arst_n <= 1;
        foreach (rg[k]) rg[k] = (k == 6) ? 8'h0f : 8'h00;
        for (int k = 0; k < 16; k++) rd(8'hc0 | 8'(k));
        chk("all_nc", mem_noncacheable, 1);
    endtask

    // Expected uncached flag and effective address
    function automatic logic [32:0] exp_mem(input logic [31:0] ad,
        input logic v86, a20n, ken_n);
        logic nc;
        logic [7:0] lo;
        int sh;
        nc = rg[0][3] && ken_n;
        if (rg[0][2] && !a20n) ad[20] = 0;
        if (rg[0][0] && v86 && ad[19:16] == 0) nc = 1;
        if (rg[0][1] && ad[31:20] == 0 && ad[19:0] >= CCN_VIDEO_BASE) nc = 1;
        for (int r = 5; r < 16; r += 3)
        begin
            lo = rg[r + 1];
            sh = 11 + lo[3:0];
            if (lo[3:0] == CCN_SIZE_ALL) nc = 1;
            else if (lo[3:0] != 0
                && (ad >> sh) == ({rg[r], lo[7:4], 12'h000} >> sh)) nc = 1;
        end
        return {nc, ad};
    endfunction

    // Main sequence
    initial
    begin
        logic [31:0] ad;
        logic [32:0] e;
        logic [8:0] pv;
        logic hp;
        do_reset();
        // Refused and unarmed accesses go outside
        wr(8'hc1, 8'hff);
        io(1, CCN_PORT_INDEX, 8'hbf, 1);
        io(1, CCN_PORT_DATA, 8'h00, 1);
        io(1, CCN_PORT_INDEX, 8'hd0, 1);
        io(1, CCN_PORT_INDEX, 8'hc1, 0);
        io(0, CCN_PORT_DATA, 8'h00, 0);
        io(1, CCN_PORT_DATA, 8'h00, 1);
        io(0, CCN_PORT_INDEX, 8'h00, 1);
        io(1, 16'h0080, 8'hc0, 1);
        for (int n = 0; n < 8; n++)
        begin
            pv = $random(seed);
            io(1, CCN_PORT_INDEX, pv[7:0] ^ 8'h80, pv[7:4] != 4'h4);
        end
        rd(8'hc1);
        wr(8'hc6, 8'h00);
        for (int n = 0; n < 150; n++)
        begin
            if (n % 3 == 0) wr(8'hc0, $random(seed));
            wr(8'hc0 | 8'({$random(seed)} % 16), $random(seed));
            @(posedge mclk);
            ad = $random(seed);
            pv = $random(seed);
            if (ad[0]) ad[31:12] = {8'h00, rg[5 + 3 * ad[2:1]],
                rg[6 + 3 * ad[2:1]][7:4]} ^ (20'h1 << ad[7:3]);
            hp = hold_ack;
            mem_addr <= ad;
            {real_v86_mode, addr20_mask_input_n, cacheable_input_n,
                cache_flush_input_n, hold_ack, suspend_request_input_n,
                core_suspended, core_rpl_set, core_rpl_valid} <= pv;
            @(posedge mclk);
            #1;
            e = exp_mem(ad, pv[8], pv[7], pv[6]);
            chk("noncache", mem_noncacheable, e[32]);
            chk("addr_eff", mem_addr_eff, e[31:0]);
            chk("inval", cache_invalidate,
                rg[0][4] && !pv[5] || rg[0][5] && pv[4] && !hp);
            chk("way", way_mode_select, rg[0][6]);
            chk("sus_oe", suspend_ack_oe, rg[0][7]);
            chk("sus_req", suspend_req, rg[0][7] && !pv[3]);
            chk("rpl_oe", {replacement_set_oe, replacement_valid_oe},
                {2{rg[1][0]}});
            chk("sus_ack", suspend_ack_output_n, !pv[2]);
            chk("rpl_set", replacement_set_output, pv[1]);
            chk("rpl_val", replacement_valid_output_n, !pv[0]);
        end
        for (int k = 0; k < 16; k++) rd(8'hc0 | 8'(k));
        do_reset();
        finish_test();
    end
endmodule // tb_top
